// ---- hdl/epiu_pkg.sv ----
// constants shared by the external pin interrupt unit
`default_nettype none
package epiu_pkg;
	localparam int EPIU_AW = 6;
	localparam int EPIU_DW = 8;
	localparam int EPIU_LOW_PINS = 8;
	localparam int EPIU_HIGH_PINS = 4;
	localparam int EPIU_SYNC_W = 13;

	// register offsets
	localparam logic [5:0] EPIU_OFS_LOW_MASK = 6'h12;
	localparam logic [5:0] EPIU_OFS_HIGH_MASK = 6'h20;
	localparam logic [5:0] EPIU_OFS_SENSE = 6'h35;
	localparam logic [5:0] EPIU_OFS_ENABLE = 6'h3b;
	localparam logic [5:0] EPIU_OFS_FLAGS = 6'h3a;

	// field positions
	localparam int EPIU_BIT_SENSE_LO = 0;
	localparam int EPIU_BIT_SENSE_HI = 1;
	localparam int EPIU_BIT_EXT = 6;
	localparam int EPIU_BIT_HIGH = 5;
	localparam int EPIU_BIT_LOW = 4;

	// writable bits per register, everything else reads zero
	localparam logic [7:0] EPIU_SENSE_WMASK = 8'h03;
	localparam logic [7:0] EPIU_GROUP_WMASK = 8'h70;
	localparam logic [7:0] EPIU_HIGH_MASK_WMASK = 8'h0f;
	localparam logic [7:0] EPIU_LOW_MASK_WMASK = 8'hff;

	// values after reset
	localparam logic [7:0] EPIU_RST_LOW_MASK = 8'h00;
	localparam logic [3:0] EPIU_RST_HIGH_MASK = 4'h0;
	localparam logic [1:0] EPIU_RST_SENSE = 2'h0;
	localparam logic [2:0] EPIU_RST_ENABLE = 3'h0;
	localparam logic [2:0] EPIU_RST_FLAGS = 3'h0;
	localparam logic [7:0] EPIU_RST_RDATA = 8'h00;

	// sense modes
	typedef enum logic [1:0] {
		EPIU_SENSE_LOW = 2'h0,
		EPIU_SENSE_ANY = 2'h1,
		EPIU_SENSE_FALL = 2'h2,
		EPIU_SENSE_RISE = 2'h3
	} epiu_sense_e;

	// vector addresses
	localparam logic [15:0] EPIU_VEC_NONE = 16'h0000;
	localparam logic [15:0] EPIU_VEC_EXT = 16'h0001;
	localparam logic [15:0] EPIU_VEC_LOW = 16'h0002;
	localparam logic [15:0] EPIU_VEC_HIGH = 16'h0003;
endpackage : epiu_pkg
`default_nettype wire

// ---- hdl/epiu_sync.sv ----
// two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
`default_nettype none
module epiu_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] meta_next;
	logic [W-1:0] stable_reg;
	logic [W-1:0] stable_next;

	// first stage feeds only the second stage
	always_comb begin
		meta_next = async_in;
		stable_next = meta_reg;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '0;
			stable_reg <= '0;
		end else begin
			meta_reg <= meta_next;
			stable_reg <= stable_next;
		end
	end

	assign sync_out = stable_reg;
endmodule : epiu_sync
`default_nettype wire

// ---- hdl/epiu_top.sv ----
// external pin and pin-change interrupt unit with its register file
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - sense field: 00 low level, 01 any change, 10 falling, 11 rising
// - interrupt pin is synchronised first; pulses over one clock always seen
// - external request only when its enable and global enable are set
// - pin activity requests even when the pin is driven as an output
// - high group change with group and global enable raises request
// - low group change with group and global enable raises request
// - reserved bits of enable and flag registers read zero
// - triggering edge sets external flag; ack or write-one clears it
// - external flag held clear while low-level sensing is chosen
// - high group change sets high flag; ack or write-one clears
// - low group change sets low flag; ack or write-one clears
// - pending, enabled and globally enabled flag vectors the core
// - each high mask bit enables change detection on one pin
// - upper reserved bits of high group mask read zero
// - low group mask: eight read-write bits, reset to zero
// - pin changes and low level give an unclocked wake signal
// - edge detection on the interrupt pin stops without the i/o clock
// - vectors: external 0x0001, low group 0x0002, high group 0x0003
module epiu_top
	import epiu_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [5:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic ext_irq_pin,
	input wire logic [7:0] low_group_pins,
	input wire logic [3:0] high_group_pins,
	input wire logic io_clk_run,
	input wire logic global_irq_enable,
	input wire logic ack_ext,
	input wire logic ack_low,
	input wire logic ack_high,
	output logic ext_irq_request,
	output logic low_group_request,
	output logic high_group_request,
	output logic irq_valid,
	output logic [15:0] irq_vector,
	output logic async_wake
);
	// synchronised pins and their previous samples
	logic [12:0] pins_raw;
	logic [12:0] pins_sync;
	logic [12:0] pins_prev_reg;
	logic [12:0] pins_prev_next;
	logic io_run_sync;

	// software-visible state
	logic [7:0] low_mask_reg;
	logic [7:0] low_mask_next;
	logic [3:0] high_mask_reg;
	logic [3:0] high_mask_next;
	logic [1:0] sense_reg;
	logic [1:0] sense_next;
	logic [2:0] enable_reg;
	logic [2:0] enable_next;
	logic [2:0] flags_reg;
	logic [2:0] flags_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;

	// request outputs
	logic ext_req_reg;
	logic ext_req_next;
	logic low_req_reg;
	logic low_req_next;
	logic high_req_reg;
	logic high_req_next;
	logic valid_reg;
	logic valid_next;
	logic [15:0] vector_reg;
	logic [15:0] vector_next;

	// decode and event terms
	logic wr_low_mask;
	logic wr_high_mask;
	logic wr_sense;
	logic wr_enable;
	logic wr_flags;
	logic ext_s;
	logic ext_p;
	logic ext_trig;
	logic level_mode;
	logic [7:0] low_change;
	logic [3:0] high_change;
	logic low_trig;
	logic high_trig;
	logic [2:0] flag_set;
	logic [2:0] flag_clr;
	logic [2:0] flags_view;
	logic [7:0] low_live;
	logic [3:0] high_live;
	logic ext_pending;
	logic low_pending;
	logic high_pending;

	// the pin level is read regardless of port direction, so an output
	// driven by software still reaches the detectors
	assign pins_raw = {ext_irq_pin, high_group_pins, low_group_pins};

	epiu_sync #(
		.W(EPIU_SYNC_W)
	) u_pin_sync (
		.clk(clk),
		.rst_n(rst_n),
		.async_in(pins_raw),
		.sync_out(pins_sync)
	);

	epiu_sync #(
		.W(1)
	) u_io_sync (
		.clk(clk),
		.rst_n(rst_n),
		.async_in(io_clk_run),
		.sync_out(io_run_sync)
	);

	assign ext_s = pins_sync[12];
	assign ext_p = pins_prev_reg[12];
	assign level_mode = (sense_reg == EPIU_SENSE_LOW);

	// register decode
	always_comb begin
		wr_low_mask = reg_wr && (reg_addr == EPIU_OFS_LOW_MASK);
		wr_high_mask = reg_wr && (reg_addr == EPIU_OFS_HIGH_MASK);
		wr_sense = reg_wr && (reg_addr == EPIU_OFS_SENSE);
		wr_enable = reg_wr && (reg_addr == EPIU_OFS_ENABLE);
		wr_flags = reg_wr && (reg_addr == EPIU_OFS_FLAGS);
	end

	// edge detector on the synchronised interrupt pin; a pulse held over
	// one clock is always caught by two successive samples
	always_comb begin
		ext_trig = 1'b0;
		case (epiu_sense_e'(sense_reg))
			EPIU_SENSE_LOW: ext_trig = 1'b0;
			EPIU_SENSE_ANY: ext_trig = ext_s ^ ext_p;
			EPIU_SENSE_FALL: ext_trig = ext_p & ~ext_s;
			EPIU_SENSE_RISE: ext_trig = ~ext_p & ext_s;
			default: ext_trig = 1'b0;
		endcase
		// without the i/o clock no edge is recognised
		if (!io_run_sync) begin
			ext_trig = 1'b0;
		end
	end

	// per-pin change detection gated by its mask bit
	genvar gi;
	generate
		for (gi = 0; gi < EPIU_LOW_PINS; gi++) begin : g_low
			assign low_change[gi] = low_mask_reg[gi]
				& (pins_sync[gi] ^ pins_prev_reg[gi]);
			assign low_live[gi] = low_mask_reg[gi]
				& (low_group_pins[gi] ^ pins_sync[gi]);
		end
		for (gi = 0; gi < EPIU_HIGH_PINS; gi++) begin : g_high
			assign high_change[gi] = high_mask_reg[gi]
				& (pins_sync[EPIU_LOW_PINS + gi]
				^ pins_prev_reg[EPIU_LOW_PINS + gi]);
			assign high_live[gi] = high_mask_reg[gi]
				& (high_group_pins[gi]
				^ pins_sync[EPIU_LOW_PINS + gi]);
		end
	endgenerate

	assign low_trig = |low_change;
	assign high_trig = |high_change;

	// unclocked wake: raw pin against its settled sample, and a raw low
	// level; lets a sleep controller restart clocks before any edge
	always_comb begin
		async_wake = 1'b0;
		if (enable_reg[2] && level_mode && !ext_irq_pin) begin
			async_wake = 1'b1;
		end
		if (enable_reg[1] && (|high_live)) begin
			async_wake = 1'b1;
		end
		if (enable_reg[0] && (|low_live)) begin
			async_wake = 1'b1;
		end
	end

	// flag set and clear terms; index 2 external, 1 high, 0 low
	always_comb begin
		flag_set = {ext_trig, high_trig, low_trig};
		flag_clr = {ack_ext, ack_high, ack_low};
		if (wr_flags) begin
			flag_clr = flag_clr | {reg_wdata[EPIU_BIT_EXT],
				reg_wdata[EPIU_BIT_HIGH],
				reg_wdata[EPIU_BIT_LOW]};
		end
	end

	// register file next state
	always_comb begin
		low_mask_next = low_mask_reg;
		high_mask_next = high_mask_reg;
		sense_next = sense_reg;
		enable_next = enable_reg;
		pins_prev_next = pins_sync;
		if (wr_low_mask) begin
			low_mask_next = reg_wdata & EPIU_LOW_MASK_WMASK;
		end
		if (wr_high_mask) begin
			high_mask_next = reg_wdata[3:0];
		end
		if (wr_sense) begin
			sense_next = reg_wdata[EPIU_BIT_SENSE_HI:EPIU_BIT_SENSE_LO];
		end
		if (wr_enable) begin
			enable_next = reg_wdata[EPIU_BIT_EXT:EPIU_BIT_LOW];
		end
		// a new event in the clearing cycle is kept: set wins
		flags_next = (flags_reg & ~flag_clr) | flag_set;
		if (level_mode) begin
			flags_next[2] = 1'b0;
		end
	end

	// the forced clear lands one edge after a switch to level sensing;
	// the read path hides that edge so software never sees the bit set
	assign flags_view[2] = flags_reg[2] & ~level_mode;
	assign flags_view[1:0] = flags_reg[1:0];

	// read data stands for the one cycle after the strobe only
	always_comb begin
		rdata_next = EPIU_RST_RDATA;
		if (reg_rd) begin
			case (reg_addr)
				EPIU_OFS_LOW_MASK: rdata_next = low_mask_reg;
				EPIU_OFS_HIGH_MASK: rdata_next = {4'h0, high_mask_reg};
				EPIU_OFS_SENSE: rdata_next = {6'h00, sense_reg};
				EPIU_OFS_ENABLE: rdata_next = {1'b0, enable_reg, 4'h0};
				EPIU_OFS_FLAGS: rdata_next = {1'b0, flags_view, 4'h0};
				default: rdata_next = EPIU_RST_RDATA;
			endcase
		end
	end

	// requests toward the core, gated by group and global enable
	always_comb begin
		if (level_mode) begin
			// low level requests directly while held, no flag involved
			ext_pending = ~ext_s;
		end else begin
			ext_pending = flags_reg[2];
		end
		ext_pending = ext_pending & enable_reg[2] & global_irq_enable;
		high_pending = flags_reg[1] & enable_reg[1] & global_irq_enable;
		low_pending = flags_reg[0] & enable_reg[0] & global_irq_enable;
		ext_req_next = ext_pending;
		low_req_next = low_pending;
		high_req_next = high_pending;
		valid_next = ext_pending | low_pending | high_pending;
		// lowest vector address wins when several are pending
		if (ext_pending) begin
			vector_next = EPIU_VEC_EXT;
		end else if (low_pending) begin
			vector_next = EPIU_VEC_LOW;
		end else if (high_pending) begin
			vector_next = EPIU_VEC_HIGH;
		end else begin
			vector_next = EPIU_VEC_NONE;
		end
		// an acknowledged source drops at once so it is not taken twice
		if (ack_ext) begin
			ext_req_next = 1'b0;
		end
		if (ack_low) begin
			low_req_next = 1'b0;
		end
		if (ack_high) begin
			high_req_next = 1'b0;
		end
		if (ack_ext || ack_low || ack_high) begin
			valid_next = 1'b0;
			vector_next = EPIU_VEC_NONE;
		end
	end

	// pin history, configuration and flags
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pins_prev_reg <= '0;
			low_mask_reg <= EPIU_RST_LOW_MASK;
			high_mask_reg <= EPIU_RST_HIGH_MASK;
			sense_reg <= EPIU_RST_SENSE;
			enable_reg <= EPIU_RST_ENABLE;
			flags_reg <= EPIU_RST_FLAGS;
		end else begin
			pins_prev_reg <= pins_prev_next;
			low_mask_reg <= low_mask_next;
			high_mask_reg <= high_mask_next;
			sense_reg <= sense_next;
			enable_reg <= enable_next;
			flags_reg <= flags_next;
		end
	end

	// read data register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= EPIU_RST_RDATA;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	// request registers; registered so the core never sees a glitch
	// from the flag and enable terms settling
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_req_reg <= 1'b0;
			low_req_reg <= 1'b0;
			high_req_reg <= 1'b0;
			valid_reg <= 1'b0;
			vector_reg <= EPIU_VEC_NONE;
		end else begin
			ext_req_reg <= ext_req_next;
			low_req_reg <= low_req_next;
			high_req_reg <= high_req_next;
			valid_reg <= valid_next;
			vector_reg <= vector_next;
		end
	end

	assign reg_rdata = rdata_reg;
	assign ext_irq_request = ext_req_reg;
	assign low_group_request = low_req_reg;
	assign high_group_request = high_req_reg;
	assign irq_valid = valid_reg;
	assign irq_vector = vector_reg;
endmodule : epiu_top
`default_nettype wire

// ---- bench/epiu_assertions.sv ----
// port assertions for the pin interrupt unit
`timescale 1ns/1ps
`default_nettype none
module epiu_assertions (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic global_irq_enable,
	input wire logic ack_ext,
	input wire logic ack_low,
	input wire logic ack_high,
	input wire logic ext_irq_request,
	input wire logic low_group_request,
	input wire logic high_group_request,
	input wire logic irq_valid,
	input wire logic [15:0] irq_vector
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic any_req;
	logic ack_any;
	assign any_req = ext_irq_request | low_group_request | high_group_request;
	assign ack_any = ack_ext | ack_low | ack_high;
	AST_GIE_GATE: assert property (
		!global_irq_enable |=> !any_req)
		else $error("request with global enable low");
	AST_EXT_VEC: assert property (
		ext_irq_request && !$past(ack_any) |-> irq_vector == 16'h0001)
		else $error("external vector wrong");
	AST_LOW_VEC: assert property (
		low_group_request && !ext_irq_request && !$past(ack_any)
		|-> irq_vector == 16'h0002)
		else $error("low group vector wrong");
	AST_HIGH_VEC: assert property (
		high_group_request && !ext_irq_request && !low_group_request
		&& !$past(ack_any) |-> irq_vector == 16'h0003)
		else $error("high group vector wrong");
	AST_VALID_ANY: assert property (
		!$past(ack_any) |-> irq_valid == any_req)
		else $error("valid does not follow requests");
	AST_ACK_EXT: assert property (ack_ext |=> !ext_irq_request)
		else $error("external request kept after ack");
	AST_ACK_LOW: assert property (ack_low |=> !low_group_request)
		else $error("low request kept after ack");
	AST_ACK_HIGH: assert property (ack_high |=> !high_group_request)
		else $error("high request kept after ack");
	AST_ACK_IDLE: assert property (
		ack_any |=> !irq_valid && irq_vector == 16'h0000)
		else $error("vector shown in ack cycle");
endmodule : epiu_assertions
bind epiu_top epiu_assertions u_chk (
	.clk(clk),
	.rst_n(rst_n),
	.global_irq_enable(global_irq_enable),
	.ack_ext(ack_ext),
	.ack_low(ack_low),
	.ack_high(ack_high),
	.ext_irq_request(ext_irq_request),
	.low_group_request(low_group_request),
	.high_group_request(high_group_request),
	.irq_valid(irq_valid),
	.irq_vector(irq_vector)
);
`default_nettype wire

// ---- bench/epiu_core_model.sv ----
// core model acknowledging pending requests by vector
`timescale 1ns/1ps
`default_nettype none
module epiu_core_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic accept,
	input wire logic irq_valid,
	input wire logic [15:0] irq_vector,
	output logic ack_ext,
	output logic ack_low,
	output logic ack_high
);
	logic busy;
	assign busy = ack_ext | ack_low | ack_high;
	// skips the cycle after an ack: the old vector is still on show there
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{ack_ext, ack_low, ack_high} <= 3'h0;
		end else if (accept && irq_valid && !busy) begin
			ack_ext <= irq_vector == 16'h0001;
			ack_low <= irq_vector == 16'h0002;
			ack_high <= irq_vector == 16'h0003;
		end else begin
			{ack_ext, ack_low, ack_high} <= 3'h0;
		end
	end
endmodule : epiu_core_model
`default_nettype wire

// ---- bench/epiu_top_tb_top.sv ----
// testbench for the pin interrupt unit
`timescale 1ns/1ps
`default_nettype none
module epiu_top_tb_top import epiu_pkg::*; ;
	logic clk = 0, rst_n = 0, wr_s = 0, rd_s = 0, pin = 0, io_run = 1;
	logic gie = 0, accept = 0, ack_e, ack_l, ack_h, req_e, req_l, req_h;
	logic valid, wake;
	logic [5:0] addr = 0;
	logic [7:0] wdata = 0, lo_p = 0, rdata;
	logic [3:0] hi_p = 0;
	logic [15:0] vec;
	int n_errors = 0, n_checks = 0;
	initial forever #2.5 clk = ~clk;
	epiu_top dut (.clk(clk), .rst_n(rst_n), .reg_addr(addr),
		.reg_wdata(wdata), .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdata),
		.ext_irq_pin(pin), .low_group_pins(lo_p), .high_group_pins(hi_p),
		.io_clk_run(io_run), .global_irq_enable(gie), .ack_ext(ack_e),
		.ack_low(ack_l), .ack_high(ack_h), .ext_irq_request(req_e),
		.low_group_request(req_l), .high_group_request(req_h),
		.irq_valid(valid), .irq_vector(vec), .async_wake(wake));
	epiu_core_model core (.clk(clk), .rst_n(rst_n), .accept(accept),
		.irq_valid(valid), .irq_vector(vec), .ack_ext(ack_e),
		.ack_low(ack_l), .ack_high(ack_h));
	task automatic print_verdict();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : print_verdict
	task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic cyc(int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	task automatic wr(logic [5:0] a, logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask : wr
	// read data stand only in the cycle after the strobe; taken at the
	// edge that closes that cycle, before the register updates
	task automatic rchk(string nm, logic [5:0] a, logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		@(posedge clk);
		chk(nm, rdata, exp);
	endtask : rchk
	// core takes every pending request; a hang counts as a mismatch
	task automatic drain();
		int i;
		accept <= 1'b1;
		for (i = 0; i < 20 && (req_e | req_l | req_h) !== 1'b0; i++)
			cyc(1);
		accept <= 1'b0;
		if (i == 20) begin
			n_errors++;
			print_verdict();
		end
	endtask : drain
	task automatic t_regs();
		rchk("low_mask", EPIU_OFS_LOW_MASK, 8'h00);
		rchk("high_mask", EPIU_OFS_HIGH_MASK, 8'h00);
		rchk("sense", EPIU_OFS_SENSE, 8'h00);
		rchk("enable", EPIU_OFS_ENABLE, 8'h00);
		wr(EPIU_OFS_LOW_MASK, 8'hff);
		wr(EPIU_OFS_HIGH_MASK, 8'hff);
		wr(EPIU_OFS_ENABLE, 8'hff);
		wr(6'h00, 8'hff);
		rchk("low_mask", EPIU_OFS_LOW_MASK, 8'hff);
		rchk("high_mask", EPIU_OFS_HIGH_MASK, 8'h0f);
		rchk("enable", EPIU_OFS_ENABLE, 8'h70);
		rchk("unmapped", 6'h00, 8'h00);
		wr(EPIU_OFS_LOW_MASK, 8'h00);
		wr(EPIU_OFS_HIGH_MASK, 8'h00);
	endtask : t_regs
	task automatic t_ext();
		logic e;
		wr(EPIU_OFS_ENABLE, 8'h40);
		gie <= 1'b1;
		for (int m = 1; m < 4; m++) begin
			wr(EPIU_OFS_SENSE, 8'(m));
			for (int k = 0; k < 2; k++) begin
				wr(EPIU_OFS_FLAGS, 8'h40);
				pin <= ~pin;
				cyc(5);
				e = (k == 0) ? (m != 2) : (m != 3);
				chk("ext_req", req_e, e);
				chk("ext_vec", vec, e ? 16'h0001 : 16'h0000);
				rchk("flags", EPIU_OFS_FLAGS, {1'b0, e, 6'h00});
			end
		end
		pin <= 1'b1;
		cyc(1);
		pin <= 1'b0;
		cyc(5);
		rchk("short_pulse", EPIU_OFS_FLAGS, 8'h40);
		drain();
		rchk("ext_acked", EPIU_OFS_FLAGS, 8'h00);
		pin <= 1'b1;
		cyc(1);
		pin <= 1'b0;
		cyc(5);
		rchk("re_set", EPIU_OFS_FLAGS, 8'h40);
		// flag left set on purpose: level mode must hide it
		wr(EPIU_OFS_SENSE, 8'h00);
		cyc(4);
		chk("lvl_req", req_e, 1'b1);
		rchk("lvl_flags", EPIU_OFS_FLAGS, 8'h00);
		gie <= 1'b0;
		cyc(2);
		chk("gie_off", req_e, 1'b0);
		gie <= 1'b1;
		wr(EPIU_OFS_SENSE, 8'h02);
		rchk("sense_wr", EPIU_OFS_SENSE, 8'h02);
		pin <= 1'b1;
		cyc(5);
		io_run <= 1'b0;
		cyc(3);
		pin <= 1'b0;
		cyc(5);
		rchk("io_halt", EPIU_OFS_FLAGS, 8'h00);
		io_run <= 1'b1;
		wr(EPIU_OFS_ENABLE, 8'h30);
	endtask : t_ext
	task automatic t_groups();
		wr(EPIU_OFS_FLAGS, 8'h70);
		wr(EPIU_OFS_LOW_MASK, 8'h01);
		wr(EPIU_OFS_HIGH_MASK, 8'h08);
		lo_p <= 8'hfe;
		hi_p <= 4'h7;
		cyc(5);
		rchk("masked", EPIU_OFS_FLAGS, 8'h00);
		lo_p[0] <= 1'b1;
		#1 chk("wake", wake, 1'b1);
		cyc(5);
		chk("low_req", req_l, 1'b1);
		chk("low_vec", vec, 16'h0002);
		chk("low_valid", valid, 1'b1);
		hi_p[3] <= 1'b1;
		cyc(5);
		chk("high_req", req_h, 1'b1);
		chk("prio_vec", vec, 16'h0002);
		rchk("grp_flags", EPIU_OFS_FLAGS, 8'h30);
		drain();
		rchk("acked", EPIU_OFS_FLAGS, 8'h00);
	endtask : t_groups
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_ext();
		t_groups();
		print_verdict();
	end
endmodule : epiu_top_tb_top
`default_nettype wire
